// [src/dcc_dosing_cut_controller.sv]
// Dosing cut controller: feed relay cut points, tolerance and material checks
// Notes on behaviour
// - Start mode: auto, key, input, or either.
// - Basic discharge ignores start confirmation setting.
// - Stored setpoint used only without prompt.
// - Slow relay cut at setpoint minus fall.
// - Fall adjusted by error times percent over 100.
// - Zero percent freezes fall compensation.
// - Correction clamped to limit; zero means none.
// - Fast cut also subtracts slow band.
// - Over upper tolerance raises tolerance fault.
// - Under lower tolerance raises tolerance fault.
// - Tolerances independent, one shared unit: weight or percent.
// - Zero tolerance disables that check.
// - Operator accepts or rejects; reject repeats cycle.
// - Zero lack window disables material detection.
// - Weight must rise enough each window.
// - Material error: cancel, resume, or end.
// - Charge end samples weight at choice.
// - Discharge end keeps weight latched at error.
// - Settle delay after stability, restarts on instability.
// - Settle delay held in tenths of seconds.
// - Pre-dose action pulses just before dosing.
// - Post-dose action pulses just after completion.
// - Two-speed starts both relays; one-speed slow only.
// - Entry modes last and zero both take the entered value; none takes stored.
`timescale 1ns/10ps
module dcc_dosing_cut_controller
    import dcc_pkg::*;
#(
    parameter int TENTH_CYCLES = TENTH_CYC
) (
    input  wire logic                clk,
    input  wire logic                reset,
    input  wire dcc_cfg_t            cfg,
    input  wire logic                go,
    input  wire logic                key_confirm,
    input  wire logic                start_input_pin,
    input  wire logic signed [W-1:0] weight,
    input  wire logic                stable_pin,
    input  wire logic                accept,
    input  wire logic                reject,
    input  wire dcc_choice_t         lack_choice,
    output dcc_relay_t               relays,
    output logic signed [W-1:0]      recorded_weight,
    output logic signed [W-1:0]      fall_compensation,
    output logic                     done,
    output logic                     busy,
    output logic                     awaiting_decision
);
    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    logic [1:0] in_sync_reg;
    logic [1:0] stb_sync_reg;
    always_ff @(posedge clk) begin
        if (reset) begin
            in_sync_reg  <= 2'h0;
            stb_sync_reg <= 2'h0;
        end else begin
            in_sync_reg  <= {in_sync_reg[0], start_input_pin};
            stb_sync_reg <= {stb_sync_reg[0], stable_pin};
        end
    end
    wire start_in = in_sync_reg[1];
    wire stable   = stb_sync_reg[1];

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic signed [W-1:0] pct_of(input logic signed [W-1:0] v,
                                                     input logic [7:0] p);
        logic signed [W+8:0] prod;
        prod = v * $signed({1'b0, p});
        return W'(prod / $signed({2'h0, PCT_DIV}));
    endfunction

    function automatic logic signed [W-1:0] tol_abs(input logic signed [W-1:0] t,
                                                      input logic sel,
                                                      input logic signed [W-1:0] ref_v);
        return sel ? pct_of(ref_v, t[7:0]) : t;
    endfunction

    // ------------------------------------------------------------
    // Cut points and confirmation
    // ------------------------------------------------------------
    typedef enum logic [2:0] {S_IDLE, S_PRE, S_WAIT, S_FEED, S_SETTLE,
                              S_TOL, S_LACK, S_POST} dcc_state_t;
    dcc_state_t state_reg, state_next;

    logic signed [W-1:0] target_reg, base_reg, last_entry_reg, lack_w_reg;
    logic signed [W-1:0] win_ref_reg;
    logic [31:0]         tick_reg;
    logic [15:0]         tenths_reg;
    logic                fast_reg, slow_reg, tolf_reg, matf_reg;
    logic                lack_end_reg;

    wire dcc_start_t eff_start = (cfg.discharge && cfg.basic) ? ST_AUTO : cfg.start_mode;
    wire confirmed = (eff_start == ST_AUTO) ||
                     (eff_start == ST_KEY && key_confirm) ||
                     (eff_start == ST_INPUT && start_in) ||
                     (eff_start == ST_KEY_INPUT && (key_confirm || start_in));

    wire logic signed [W-1:0] dose_amount =
        (cfg.prompt_quantity_mode == PQ_NONE) ? cfg.setpoint_quantity :
        cfg.prompt_value;

    // Dosed amount is signed divisions; discharge counts a falling weight
    wire logic signed [W-1:0] dosed = cfg.discharge ? (base_reg - weight) : (weight - base_reg);
    wire logic signed [W-1:0] slow_cut = target_reg - fall_compensation;
    wire logic signed [W-1:0] fast_cut = slow_cut - cfg.slow_band;

    // Final error and bounded correction
    wire logic signed [W-1:0] final_amt = lack_end_reg ? recorded_weight : dosed;
    wire logic signed [W-1:0] err = target_reg - final_amt;
    wire logic signed [W-1:0] corr_raw = pct_of(err, cfg.corr_pct);
    wire logic signed [W-1:0] lim = cfg.correction_limit;
    wire logic signed [W-1:0] corr =
        (lim == '0) ? corr_raw :
        (corr_raw > lim) ? lim : (corr_raw < -lim) ? -lim : corr_raw;

    wire logic signed [W-1:0] up_t = tol_abs(cfg.upper_tolerance, cfg.tolerance_unit_select, final_amt);
    wire logic signed [W-1:0] lo_t = tol_abs(cfg.lower_tolerance, cfg.tolerance_unit_select, final_amt);
    wire over_fault  = (cfg.upper_tolerance != '0) && (final_amt - target_reg > up_t);
    wire under_fault = (cfg.lower_tolerance != '0) && (target_reg - final_amt > lo_t);

    // Lack-of-material window in tenths; rise must exceed divisions
    wire tenth_tick = (tick_reg == 32'(TENTH_CYCLES - 1));
    wire logic [15:0] win_tenths = 16'(cfg.lack_window_s) * 16'(SEC_TENTHS);
    wire lack_on = (cfg.lack_window_s != 8'h0);
    // Window only runs while feeding, so it never restarts the settle count
    wire win_end = (state_reg == S_FEED) && lack_on && tenth_tick &&
                   (tenths_reg + 16'h1 >= win_tenths);
    wire logic signed [W-1:0] rise = cfg.discharge ? (win_ref_reg - weight) : (weight - win_ref_reg);
    wire lack_hit = win_end && (rise <= $signed(W'(cfg.min_rise_divisions)));
    wire settle_done = stable && (tenths_reg >= cfg.settle_delay);

    // ------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------
    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            S_IDLE:   if (go) state_next = S_PRE;
            S_PRE:    state_next = S_WAIT;
            S_WAIT:   if (confirmed) state_next = S_FEED;
            S_FEED:   if (lack_hit) state_next = S_LACK;
                      else if (dosed >= slow_cut) state_next = S_SETTLE;
            S_SETTLE: if (settle_done) state_next = S_TOL;
            S_TOL:    if (!(over_fault || under_fault) || accept) state_next = S_POST;
                      else if (reject) state_next = S_PRE;
            S_LACK: begin
                unique case (lack_choice)
                    LC_CANCEL: state_next = S_IDLE;
                    LC_RESUME: state_next = S_FEED;
                    LC_END:    state_next = S_SETTLE;
                    LC_NONE:   state_next = S_LACK;
                endcase
            end
            S_POST:   state_next = S_IDLE;
            default:  state_next = S_IDLE;
        endcase
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            state_reg <= S_IDLE;
        end else begin
            state_reg <= state_next;
        end
    end

    // Timebase: counts tenths; reset at window end, state change, or instability while settling
    wire time_clr = (state_reg != state_next) || win_end ||
                    (state_reg == S_SETTLE && !stable);
    always_ff @(posedge clk) begin
        if (reset || time_clr) begin
            tick_reg   <= 32'h0;
            tenths_reg <= 16'h0;
        end else begin
            tick_reg   <= tenth_tick ? 32'h0 : tick_reg + 32'h1;
            tenths_reg <= (tenth_tick && tenths_reg != 16'hffff) ? tenths_reg + 16'h1 : tenths_reg;
        end
    end

    // ------------------------------------------------------------
    // Data path
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (reset) begin
            target_reg        <= '0;
            base_reg          <= '0;
            last_entry_reg    <= '0;
            win_ref_reg       <= '0;
            lack_w_reg        <= '0;
            recorded_weight   <= '0;
            fall_compensation <= '0;
            lack_end_reg      <= 1'b0;
            fast_reg          <= 1'b0;
            slow_reg          <= 1'b0;
            tolf_reg          <= 1'b0;
            matf_reg          <= 1'b0;
        end else begin
            if (state_reg == S_IDLE && go) begin
                fall_compensation <= cfg.fall_comp_init;
                tolf_reg          <= 1'b0;
            end
            if (state_reg == S_PRE) begin
                target_reg   <= dose_amount;
                base_reg     <= weight;
                win_ref_reg  <= weight;
                lack_end_reg <= 1'b0;
                matf_reg     <= 1'b0;
                if (cfg.prompt_quantity_mode != PQ_NONE) begin
                    last_entry_reg <= dose_amount;
                end
            end
            if (state_reg == S_WAIT && confirmed) begin
                fast_reg <= cfg.two_speed;
                slow_reg <= 1'b1;
            end
            if (state_reg == S_FEED) begin
                if (win_end) begin
                    win_ref_reg <= weight;
                end
                if (dosed >= fast_cut) begin
                    fast_reg <= 1'b0;
                end
                if (dosed >= slow_cut || lack_hit) begin
                    slow_reg <= 1'b0;
                    fast_reg <= 1'b0;
                end
                if (lack_hit) begin
                    matf_reg   <= 1'b1;
                    lack_w_reg <= dosed;
                end
            end
            if (state_reg == S_LACK && lack_choice != LC_NONE) begin
                matf_reg <= 1'b0;
                if (lack_choice == LC_END) begin
                    lack_end_reg    <= 1'b1;
                    recorded_weight <= cfg.discharge ? lack_w_reg : dosed;
                end else if (lack_choice == LC_RESUME) begin
                    win_ref_reg <= weight;
                    fast_reg    <= cfg.two_speed && (dosed < fast_cut);
                    slow_reg    <= 1'b1;
                end
            end
            if (state_reg == S_SETTLE && settle_done) begin
                tolf_reg <= over_fault || under_fault;
                if (!lack_end_reg) begin
                    recorded_weight <= dosed;
                end
                if (cfg.corr_pct != 8'h0) begin
                    fall_compensation <= fall_compensation - corr;
                end
            end
            if (state_reg == S_TOL && (accept || reject)) begin
                tolf_reg <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign relays.fast_feed              = fast_reg;
    assign relays.slow_feed              = slow_reg;
    assign relays.tolerance_fault_output = tolf_reg;
    assign relays.material_fault         = matf_reg;
    assign relays.general_error          = tolf_reg || matf_reg;
    assign relays.pre_dose_action        = (state_reg == S_PRE);
    assign relays.post_dose_action       = (state_reg == S_POST);
    assign relays.active                 = (state_reg != S_IDLE);
    assign done              = (state_reg == S_POST);
    assign busy              = (state_reg != S_IDLE);
    assign awaiting_decision = (state_reg == S_TOL && tolf_reg) || (state_reg == S_LACK);
endmodule

// [src/dcc_pkg.sv]
// Package: constants and types for the dosing cut controller
package dcc_pkg;
    localparam int W = 24;
    localparam int CLK_HZ = 50_000_000;
    localparam int TENTH_S_NS = 100_000_000;
    localparam int CLK_NS = 20;
    localparam int TENTH_CYC = TENTH_S_NS / CLK_NS;
    localparam int SEC_TENTHS = 10;
    localparam logic [7:0] CORR_PCT_RST = 8'h32;
    localparam logic [6:0] PCT_DIV = 7'h64;

    typedef enum logic [1:0] {ST_AUTO, ST_KEY, ST_INPUT, ST_KEY_INPUT} dcc_start_t;
    typedef enum logic [1:0] {PQ_NONE, PQ_LAST, PQ_ZERO, PQ_RSVD} dcc_prompt_t;
    typedef enum logic [1:0] {LC_NONE, LC_CANCEL, LC_RESUME, LC_END} dcc_choice_t;

    typedef struct packed {
        logic               two_speed;
        logic               discharge;
        logic               basic;
        dcc_start_t         start_mode;
        dcc_prompt_t        prompt_quantity_mode;
        logic signed [W-1:0] setpoint_quantity;
        logic signed [W-1:0] prompt_value;
        logic signed [W-1:0] fall_comp_init;
        logic [7:0]         corr_pct;
        logic signed [W-1:0] correction_limit;
        logic signed [W-1:0] slow_band;
        logic               tolerance_unit_select;
        logic signed [W-1:0] upper_tolerance;
        logic signed [W-1:0] lower_tolerance;
        logic [7:0]         lack_window_s;
        logic [7:0]         min_rise_divisions;
        logic [15:0]        settle_delay;
    } dcc_cfg_t;

    typedef struct packed {
        logic fast_feed;
        logic slow_feed;
        logic tolerance_fault_output;
        logic material_fault;
        logic general_error;
        logic pre_dose_action;
        logic post_dose_action;
        logic active;
    } dcc_relay_t;
endpackage

// [bench/dcc_checker.sv]
// Checker: port-level timing of the dosing cut controller
`timescale 1ns/10ps
module dcc_checker
    import dcc_pkg::*;
(
    input wire logic                clk,
    input wire logic                reset,
    input wire dcc_cfg_t            cfg,
    input wire logic                go,
    input wire logic                key_confirm,
    input wire logic                start_input_pin,
    input wire logic signed [W-1:0] weight,
    input wire logic                stable_pin,
    input wire logic                accept,
    input wire logic                reject,
    input wire dcc_choice_t         lack_choice,
    input wire dcc_relay_t          relays,
    input wire logic signed [W-1:0] recorded_weight,
    input wire logic signed [W-1:0] fall_compensation,
    input wire logic                done,
    input wire logic                busy,
    input wire logic                awaiting_decision
);
    logic signed [W-1:0]      start_w_reg;
    wire logic signed [W-1:0] target = cfg.prompt_quantity_mode == PQ_NONE ?
        cfg.setpoint_quantity : cfg.prompt_value;
    wire logic signed [W-1:0] dosed = cfg.discharge ? start_w_reg - weight : weight - start_w_reg;
    // Start weight taken while the valves are still shut, so no flow is lost
    always_ff @(posedge clk)
        if (relays.pre_dose_action)
            start_w_reg <= weight;
    // ----------
    // Assertions
    // ----------
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (reset);
    sequence pre_s;
        relays.pre_dose_action;
    endsequence
    sequence feed_s;
        relays.slow_feed ##0 relays.fast_feed == cfg.two_speed;
    endsequence
    pre_pulse_a: assert property (go && !busy |=> pre_s ##1 !relays.pre_dose_action)
        else $error("pre-dose pulse missing");
    auto_start_a: assert property (pre_s ##0 cfg.start_mode == ST_AUTO |-> ##2 feed_s)
        else $error("automatic start did not open the valves");
    slow_cut_a: assert property (relays.slow_feed && dosed >= target - fall_compensation
        |=> !relays.slow_feed) else $error("slow feed not cut");
    fast_cut_a: assert property (relays.fast_feed
        && dosed >= target - fall_compensation - cfg.slow_band |=> !relays.fast_feed)
        else $error("fast feed not cut");
    one_speed_a: assert property (!cfg.two_speed |-> !relays.fast_feed)
        else $error("fast feed used in one-speed mode");
    error_or_a: assert property (relays.general_error
        == (relays.tolerance_fault_output || relays.material_fault))
        else $error("general error relay wrong");
    tol_hold_a: assert property (relays.tolerance_fault_output && !accept && !reject && !go
        |=> relays.tolerance_fault_output) else $error("tolerance fault dropped early");
    lack_cut_a: assert property ($rose(relays.material_fault)
        |-> !relays.slow_feed && !relays.fast_feed && $past(cfg.lack_window_s) != 8'h00)
        else $error("material fault with feed open or detection off");
    fall_fixed_a: assert property (cfg.corr_pct == 8'h00 && !(go && !busy)
        |=> $stable(fall_compensation)) else $error("fall compensation moved");
    done_post_a: assert property (done |-> relays.post_dose_action ##1 !busy)
        else $error("done without post-dose pulse");
endmodule
bind dcc_dosing_cut_controller dcc_checker i_dcc_checker (
    .clk(clk), .reset(reset), .cfg(cfg), .go(go), .key_confirm(key_confirm),
    .start_input_pin(start_input_pin), .weight(weight), .stable_pin(stable_pin),
    .accept(accept), .reject(reject), .lack_choice(lack_choice), .relays(relays),
    .recorded_weight(recorded_weight), .fall_compensation(fall_compensation),
    .done(done), .busy(busy), .awaiting_decision(awaiting_decision)
);

// [bench/dcc_feed_model.sv]
// Partner model: material flowing onto the scale under the feed relays
`timescale 1ns/10ps
module dcc_feed_model
    import dcc_pkg::*;
#(
    parameter int FALL = 3
) (
    input  wire logic           clk,
    input  wire logic           reset,
    input  wire dcc_relay_t     relays,
    input  wire logic           stall,
    output logic signed [W-1:0] weight,
    output logic                stable_pin
);
    int pend;
    always_ff @(posedge clk) begin
        if (reset) begin
            weight <= '0;
            pend <= 0;
        end else if (relays.slow_feed) begin
            // A dry hopper stops the rise, which is what lack detection must catch
            if (!stall)
                weight <= weight + (relays.fast_feed ? 24'sh4 : 24'sh1);
            pend <= FALL;
        end else if (pend > 0) begin
            // Material still in the air lands after the cut
            weight <= weight + 24'sh1;
            pend <= pend - 1;
        end
    end
    assign stable_pin = !relays.slow_feed && pend == 0;
endmodule

// [bench/testbench.sv]
// Testbench: dosing cut controller against a flow model of the scale
`timescale 1ns/10ps
module testbench
    import dcc_pkg::*;
;
    typedef struct {
        int          ts;
        dcc_start_t  sm;
        dcc_prompt_t pq;
        int          sp, f0, band, pct, lim, unit, up, lo, rej;
    } dcc_row_t;
    logic                clk, reset, go, key_confirm, start_input_pin, accept, reject, stall;
    dcc_cfg_t            cfg;
    dcc_choice_t         lack_choice;
    logic signed [W-1:0] weight, recorded_weight, fall_compensation;
    logic                stable_pin, done, busy, awaiting_decision;
    dcc_relay_t          relays;
    int                  miscompares, comparisons, cycles, s0;
    dcc_row_t            rows[6];
    dcc_row_t            lrow;
    dcc_dosing_cut_controller #(.TENTH_CYCLES(10)) i_dcc_dosing_cut_controller (
        .clk(clk), .reset(reset), .cfg(cfg), .go(go), .key_confirm(key_confirm),
        .start_input_pin(start_input_pin), .weight(weight), .stable_pin(stable_pin),
        .accept(accept), .reject(reject), .lack_choice(lack_choice), .relays(relays),
        .recorded_weight(recorded_weight), .fall_compensation(fall_compensation),
        .done(done), .busy(busy), .awaiting_decision(awaiting_decision)
    );
    dcc_feed_model i_dcc_feed_model (
        .clk(clk), .reset(reset), .relays(relays), .stall(stall), .weight(weight),
        .stable_pin(stable_pin)
    );
    always #10 clk = ~clk;
    // Ceiling well above the under-a-thousand cycles the run needs
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            miscompares++;
            complete_run();
        end
    end
    task automatic check(input string what, input logic [W-1:0] exp, input logic [W-1:0] got);
        comparisons++;
        if (got !== exp) begin
            miscompares++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask
    function automatic bit tol_bad(input dcc_row_t r, input int a);
        return (r.up != 0 && (a - r.sp) * (r.unit ? 100 : 1) > r.up * (r.unit ? a : 1))
            || (r.lo != 0 && (r.sp - a) * (r.unit ? 100 : 1) > r.lo * (r.unit ? a : 1));
    endfunction
    function automatic int exp_fall(input dcc_row_t r, input int a);
        int c;
        c = (r.sp - a) * r.pct / 100;
        if (r.lim != 0 && c > r.lim)
            c = r.lim;
        if (r.lim != 0 && c < -r.lim)
            c = -r.lim;
        return r.f0 - c;
    endfunction
    // ---------------
    // Stimulus tasks
    // ---------------
    task automatic start_dose(input dcc_row_t r, input int win);
        @(posedge clk);
        cfg <= '{r.ts[0], 1'b0, 1'b0, r.sm, r.pq, W'(r.pq == PQ_NONE ? r.sp : r.sp + 100),
            W'(r.sp), W'(r.f0), 8'(r.pct), W'(r.lim), W'(r.band), r.unit[0], W'(r.up),
            W'(r.lo), 8'(win), 8'h02, 16'h0002};
        go <= 1'b1;
        @(posedge clk);
        go <= 1'b0;
        s0 = weight;
        if (r.sm != ST_AUTO) begin
            repeat (6) @(posedge clk);
            check("feed before confirm", 0, relays.slow_feed);
            if (r.sm == ST_KEY)
                key_confirm <= 1'b1;
            else
                start_input_pin <= 1'b1;
            @(posedge clk);
            key_confirm <= 1'b0;
            start_input_pin <= 1'b0;
        end
    endtask
    task automatic finish_dose(input dcc_row_t r);
        int n, t_off, a;
        bit flt, rj;
        t_off = 0;
        flt = 0;
        rj = r.rej[0];
        for (n = 0; n < 3000 && done !== 1'b1; n++) begin
            @(negedge clk);
            if (relays.slow_feed === 1'b1)
                t_off = n;
            if (awaiting_decision === 1'b1 && relays.tolerance_fault_output === 1'b1) begin
                flt = 1;
                @(posedge clk);
                accept <= !rj;
                reject <= rj;
                @(posedge clk);
                accept <= 1'b0;
                reject <= 1'b0;
                @(negedge clk);
                if (rj)
                    check("cycle repeated", 1, relays.pre_dose_action);
                if (rj)
                    s0 = weight;
                rj = 0;
            end
        end
        a = weight - s0;
        check("done", 1, done);
        check("recorded weight", W'(a), recorded_weight);
        check("fall compensation", W'(exp_fall(r, a)), fall_compensation);
        check("tolerance fault", tol_bad(r, a), flt);
        check("settle time", 1, n - t_off >= 20);
    endtask
    task automatic lack_hit(input dcc_choice_t ch);
        int n;
        stall <= 1'b1;
        for (n = 0; n < 400 && relays.material_fault !== 1'b1; n++)
            @(negedge clk);
        check("material fault", 1, relays.material_fault);
        check("feed cut on fault", 0, relays.slow_feed);
        repeat (5) @(posedge clk);
        lack_choice <= ch;
        @(posedge clk);
        lack_choice <= LC_NONE;
        stall <= 1'b0;
        repeat (2) @(posedge clk);
        check("material fault cleared", 0, relays.material_fault);
    endtask
    task complete_run;
        if (miscompares == 0 && comparisons > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    initial begin
        rows[0] = '{1, ST_AUTO, PQ_NONE, 40, 0, 5, 50, 0, 0, 0, 0, 0};
        rows[1] = '{0, ST_KEY, PQ_LAST, 30, 4, 0, 0, 0, 0, 0, 0, 0};
        rows[2] = '{1, ST_INPUT, PQ_ZERO, 40, 0, 8, 100, 1, 0, 0, 0, 0};
        rows[3] = '{1, ST_KEY_INPUT, PQ_NONE, 20, 0, 0, 50, 0, 0, 1, 0, 0};
        rows[4] = '{0, ST_AUTO, PQ_NONE, 30, 10, 0, 0, 0, 0, 0, 2, 1};
        rows[5] = '{1, ST_AUTO, PQ_NONE, 20, 0, 0, 50, 0, 1, 1, 50, 0};
        lrow = '{0, ST_AUTO, PQ_NONE, 500, 0, 0, 0, 0, 0, 0, 0, 0};
        clk = 1'b0;
        reset = 1'b1;
        cfg = '0;
        lack_choice = LC_NONE;
        {go, key_confirm, start_input_pin, accept, reject, stall} = '0;
        repeat (20) @(posedge clk);
        reset <= 1'b0;
        @(posedge clk);
        check("relays after reset", '0, W'(relays));
        check("busy after reset", 0, busy);
        foreach (rows[i]) begin
            start_dose(rows[i], 0);
            finish_dose(rows[i]);
        end
        start_dose(lrow, 1);
        lack_hit(LC_RESUME);
        check("feed resumed", 1, relays.slow_feed);
        repeat (20) @(posedge clk);
        lack_hit(LC_END);
        finish_dose(lrow);
        start_dose(lrow, 1);
        lack_hit(LC_CANCEL);
        check("cancel ends dose", 0, busy);
        complete_run();
    end
endmodule
